/* common/tscdt_cfg.svh */
// Offsets, field positions, reset values and sizes of the timer start and dead-time block.
// Assumes a 32-bit APB slave port with 12-bit byte addresses on a 250 MHz pclk.
// Operation
// - I/O control top bit 1 turns compare into capture; rising, falling or both edges.
// - Code with initial level 1 and toggle drives high, then inverts on each match.
// - After power-on reset the timer pin drives low until its I/O control is written.
// - Start bits 2 to 0 run (1) or halt (0) counters of channels 2 to 0.
// - Clearing a start bit with output pin stops counting; pin keeps its level.
// - Output-mode I/O control write with nonzero code while stopped sets pin at once to new initial level.
// - Channel 5 start bits 2, 1, 0 run or halt phase counters U, V, W.
// - Channel 5 start bits 7 to 3 read zero; software writes zero there.
// - Dead-time enable bit 0 inserts dead time when 1; it resets to 1.
// - Dead-time enable clears only by writing 0 after reading 1; else unchanged.
// - Exactly one dead-time enable register exists, belonging to channel 3.
`ifndef TSCDT_CFG_SVH
`define TSCDT_CFG_SVH

`define TSCDT_OFF_START     12'h000
`define TSCDT_OFF_CH5_START 12'h004
`define TSCDT_OFF_DT_EN     12'h008
`define TSCDT_OFF_DT_VAL    12'h00c
`define TSCDT_OFF_IOC0      12'h010
`define TSCDT_OFF_CMP0      12'h020
`define TSCDT_OFF_CNT0      12'h030
`define TSCDT_OFF_PHASE0    12'h040

`define TSCDT_CH_STEP       12'h004
`define TSCDT_START_W       3
`define TSCDT_IOC_W         4
`define TSCDT_IOC_CAP_BIT   3
`define TSCDT_IOC_INIT_BIT  2
`define TSCDT_IOC_BOTH_BIT  1
`define TSCDT_IOC_FALL_BIT  0
`define TSCDT_DT_EN_BIT     0
`define TSCDT_DT_EN_RST     1'b1
`define TSCDT_DT_VAL_W      8
`define TSCDT_DT_VAL_RST    8'h00
`define TSCDT_CNT_W         16

`endif

/* common/tscdt_pkg.sv */
// Types shared by the timer start and dead-time block.
// Assumes nothing beyond a SystemVerilog elaborator.
package tscdt_pkg;

    typedef enum logic [3:0] {
        TSCDT_ACT_HOLD   = 4'h1,
        TSCDT_ACT_LOW    = 4'h2,
        TSCDT_ACT_HIGH   = 4'h4,
        TSCDT_ACT_TOGGLE = 4'h8
    } tscdt_act_e;

endpackage

/* core/tscdt_chan.sv */
// One timer channel: counter, compare/capture register, pin control.
// Assumes write strobes are single-cycle pulses from the register slave on pclk.
`include "tscdt_cfg.svh"

module tscdt_chan #(
    parameter int CNT_W = `TSCDT_CNT_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             run,
    input  wire logic             ioc_wr,
    input  wire logic             cnt_wr,
    input  wire logic             cmp_wr,
    input  wire logic [CNT_W-1:0] wdata,
    input  wire logic             pin_i,
    output logic [`TSCDT_IOC_W-1:0] ioc,
    output logic [CNT_W-1:0]      count,
    output logic [CNT_W-1:0]      compare,
    output logic                  pin_o,
    output logic                  pin_oe
);

    function automatic tscdt_pkg::tscdt_act_e act_of(input logic [1:0] code);
        case (code)
            2'h1:    act_of = tscdt_pkg::TSCDT_ACT_LOW;
            2'h2:    act_of = tscdt_pkg::TSCDT_ACT_HIGH;
            2'h3:    act_of = tscdt_pkg::TSCDT_ACT_TOGGLE;
            default: act_of = tscdt_pkg::TSCDT_ACT_HOLD;
        endcase
    endfunction

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic rise;
    logic fall;
    logic cap_mode;
    logic cap_hit;
    logic match;

    // Pin comes from outside the clock domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign rise     = sync2_reg & ~sync3_reg;
    assign fall     = ~sync2_reg & sync3_reg;
    assign cap_mode = ioc[`TSCDT_IOC_CAP_BIT];
    assign cap_hit  = cap_mode & run &
                      (ioc[`TSCDT_IOC_BOTH_BIT] ? (rise | fall) :
                       (ioc[`TSCDT_IOC_FALL_BIT] ? fall : rise));
    assign match    = run & ~cap_mode & (count == compare);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ioc <= '0;
        else if (ioc_wr)
            ioc <= wdata[`TSCDT_IOC_W-1:0];
    end

    // Halted counter holds its value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= '0;
        else if (cnt_wr)
            count <= wdata;
        else if (run)
            count <= count + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            compare <= '0;
        else if (cmp_wr)
            compare <= wdata;
        else if (cap_hit)
            compare <= count;
    end

    // Driven low from reset until the first I/O control write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b1;
        end
        else if (ioc_wr)
        begin
            pin_oe <= ~wdata[`TSCDT_IOC_CAP_BIT];
            // Running channels keep their level; only a halted one reloads
            if (!run && !wdata[`TSCDT_IOC_CAP_BIT] && (wdata[1:0] != 2'h0))
                pin_o <= wdata[`TSCDT_IOC_INIT_BIT];
        end
        else if (match)
        begin
            // Halted counter produces no match, so the level stays put
            case (act_of(ioc[1:0]))
                tscdt_pkg::TSCDT_ACT_LOW:    pin_o <= 1'b0;
                tscdt_pkg::TSCDT_ACT_HIGH:   pin_o <= 1'b1;
                tscdt_pkg::TSCDT_ACT_TOGGLE: pin_o <= ~pin_o;
                default:                     pin_o <= pin_o;
            endcase
        end
    end

endmodule

/* core/tscdt_top.sv */
// Timer start control for channels 0 to 2, channel 5 phase counters, dead-time enable.
// Assumes an APB master on pclk; timer pins are asynchronous to pclk.
`include "tscdt_cfg.svh"

module tscdt_top #(
    parameter int CNT_W = `TSCDT_CNT_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [2:0]       timer_io_pin_i,
    output logic [2:0]            timer_io_pin_o,
    output logic [2:0]            timer_io_pin_oe,
    output logic                  dead_time_enable_o,
    output logic [`TSCDT_DT_VAL_W-1:0] dead_time_value_o
);

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr[11:2] == off[11:2]);
    endfunction

    function automatic logic [11:0] ch_off(input logic [11:0] base, input int idx);
        ch_off = base + 12'(idx * 4);
    endfunction

    logic [`TSCDT_START_W-1:0] start_reg;
    logic [`TSCDT_START_W-1:0] ch5_start_reg;
    logic                      dte_reg;
    logic                      dte_armed_reg;
    logic [`TSCDT_DT_VAL_W-1:0] dtv_reg;
    logic [CNT_W-1:0]          phase_cnt_reg [3];

    logic                      pready_next;
    logic [31:0]               prdata_next;
    logic                      pslverr_next;
    logic                      done;
    logic                      wr_done;
    logic                      rd_done;

    logic [2:0]                ioc_wr;
    logic [2:0]                cnt_wr;
    logic [2:0]                cmp_wr;
    logic [`TSCDT_IOC_W-1:0]   ioc [3];
    logic [CNT_W-1:0]          count [3];
    logic [CNT_W-1:0]          compare [3];

    // One wait state so read data always comes from a flop
    assign pready_next = psel & penable & ~pready;
    assign done        = psel & penable & pready;
    assign wr_done     = done & pwrite;
    assign rd_done     = done & ~pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= pready_next;
            if (pready_next)
            begin
                prdata  <= prdata_next;
                pslverr <= pslverr_next;
            end
            else
            begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    always_comb
    begin
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (hit(paddr, `TSCDT_OFF_START))
            prdata_next = 32'(start_reg);
        else if (hit(paddr, `TSCDT_OFF_CH5_START))
            prdata_next = 32'(ch5_start_reg);
        else if (hit(paddr, `TSCDT_OFF_DT_EN))
            prdata_next = 32'(dte_reg);
        else if (hit(paddr, `TSCDT_OFF_DT_VAL))
            prdata_next = 32'(dtv_reg);
        else
        begin
            pslverr_next = 1'b1;
            for (int i = 0; i < 3; i++)
            begin
                if (hit(paddr, ch_off(`TSCDT_OFF_IOC0, i)))
                begin
                    prdata_next  = 32'(ioc[i]);
                    pslverr_next = 1'b0;
                end
                if (hit(paddr, ch_off(`TSCDT_OFF_CMP0, i)))
                begin
                    prdata_next  = 32'(compare[i]);
                    pslverr_next = 1'b0;
                end
                if (hit(paddr, ch_off(`TSCDT_OFF_CNT0, i)))
                begin
                    prdata_next  = 32'(count[i]);
                    pslverr_next = 1'b0;
                end
                if (hit(paddr, ch_off(`TSCDT_OFF_PHASE0, i)))
                begin
                    prdata_next  = 32'(phase_cnt_reg[i]);
                    pslverr_next = 1'b0;
                end
            end
        end
    end

    // Channel 0 to 2 run control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_reg <= '0;
        else if (wr_done && hit(paddr, `TSCDT_OFF_START))
            start_reg <= pwdata[`TSCDT_START_W-1:0];
    end

    // Reserved upper bits are never stored, so they read back zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ch5_start_reg <= '0;
        else if (wr_done && hit(paddr, `TSCDT_OFF_CH5_START))
            ch5_start_reg <= pwdata[`TSCDT_START_W-1:0];
    end

    // Single dead-time enable for the unit, tied to channel 3's PWM pair
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dte_reg       <= `TSCDT_DT_EN_RST;
            dte_armed_reg <= 1'b0;
        end
        else if (done && hit(paddr, `TSCDT_OFF_DT_EN))
        begin
            if (!pwrite)
                dte_armed_reg <= dte_reg;
            else
            begin
                // Guards against a stray write disabling dead time
                if (dte_armed_reg && !pwdata[`TSCDT_DT_EN_BIT])
                    dte_reg <= 1'b0;
                dte_armed_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dtv_reg <= `TSCDT_DT_VAL_RST;
        else if (wr_done && hit(paddr, `TSCDT_OFF_DT_VAL))
            dtv_reg <= pwdata[`TSCDT_DT_VAL_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dead_time_enable_o <= `TSCDT_DT_EN_RST;
            dead_time_value_o  <= `TSCDT_DT_VAL_RST;
        end
        else
        begin
            dead_time_enable_o <= dte_reg;
            dead_time_value_o  <= dtv_reg;
        end
    end

    // Phase U, V, W sit on start bits 2, 1, 0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
                phase_cnt_reg[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (wr_done && hit(paddr, ch_off(`TSCDT_OFF_PHASE0, i)))
                    phase_cnt_reg[i] <= pwdata[CNT_W-1:0];
                else if (ch5_start_reg[2-i])
                    phase_cnt_reg[i] <= phase_cnt_reg[i] + 1'b1;
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            ioc_wr[i] = wr_done & hit(paddr, ch_off(`TSCDT_OFF_IOC0, i));
            cmp_wr[i] = wr_done & hit(paddr, ch_off(`TSCDT_OFF_CMP0, i));
            cnt_wr[i] = wr_done & hit(paddr, ch_off(`TSCDT_OFF_CNT0, i));
        end
    end

    for (genvar g = 0; g < 3; g++)
    begin : g_chan
        tscdt_chan #(
            .CNT_W (CNT_W)
        ) u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .run     (start_reg[g]),
            .ioc_wr  (ioc_wr[g]),
            .cnt_wr  (cnt_wr[g]),
            .cmp_wr  (cmp_wr[g]),
            .wdata   (pwdata[CNT_W-1:0]),
            .pin_i   (timer_io_pin_i[g]),
            .ioc     (ioc[g]),
            .count   (count[g]),
            .compare (compare[g]),
            .pin_o   (timer_io_pin_o[g]),
            .pin_oe  (timer_io_pin_oe[g])
        );
    end

endmodule

/* dv/tscdt_pins_model.sv */
// Sensor and power-stage side of the three timer pins.
// Assumes the bench sets ext_lvl, the level the sensor puts on a released pin.
module tscdt_pins_model (
    input  wire logic [2:0] pin_o,
    input  wire logic [2:0] pin_oe,
    input  wire logic [2:0] ext_lvl,
    output logic [2:0]      pin_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // Sensor drives only a released pin, so no fight on a driven one
    always_comb
        pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule

/* dv/tscdt_top_properties.sv */
// Port checker for the timer start and dead-time block.
// Assumes APB answers with one wait state and writes land at pready.
module tscdt_top_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  timer_io_pin_o,
    input wire logic [2:0]  timer_io_pin_oe,
    input wire logic        dead_time_enable_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wd;
    logic ioc_seen;
    logic run0;
    logic dt_first;
    logic dt_clr;
    assign wd = psel && penable && pready && pwrite && !pslverr;
    // Completed write of 0 to the dead-time enable register
    assign dt_clr = wd && paddr == 12'h008 && !pwdata[0];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ioc_seen <= 1'b0;
        else if (wd && paddr[11:4] == 8'h01)
            ioc_seen <= 1'b1;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            run0 <= 1'b0;
        else if (wd && paddr == 12'h000)
            run0 <= pwdata[0];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            dt_first <= 1'b1;
        else
            dt_first <= 1'b0;
    property p_rdy;
        psel && $rose(penable) |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_err;
        pready && (paddr >= 12'h04c || (paddr >= 12'h010 && paddr[3:2] == 2'h3)) |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no error on unmapped");
    property p_rsvd;
        pready && !pwrite && paddr == 12'h004 |-> prdata[31:3] == 29'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_rstpin;
        !ioc_seen |-> timer_io_pin_o == 3'h0;
    endproperty
    a_rstpin: assert property (p_rstpin) else $error("pin high early");
    property p_init;
        wd && paddr == 12'h010 && !run0 && !pwdata[3] && pwdata[1:0] != 2'h0
            |=> timer_io_pin_o[0] == $past(pwdata[2]);
    endproperty
    a_init: assert property (p_init) else $error("initial level wrong");
    property p_oe;
        wd && paddr == 12'h010 |=> timer_io_pin_oe[0] == !$past(pwdata[3]);
    endproperty
    a_oe: assert property (p_oe) else $error("enable wrong");
    property p_dtclr;
        $fell(dead_time_enable_o) |-> $past(dt_clr, 2);
    endproperty
    a_dtclr: assert property (p_dtclr) else $error("dead time cleared");
    property p_dtrst;
        dt_first |-> dead_time_enable_o;
    endproperty
    a_dtrst: assert property (p_dtrst) else $error("dead time reset");
    c_cap: cover property (wd && paddr == 12'h010 && pwdata[3]);
    c_dt: cover property ($fell(dead_time_enable_o));
    c_err: cover property (pready && pslverr);
endmodule

bind tscdt_top tscdt_top_properties i_tscdt_top_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_io_pin_o(timer_io_pin_o),
    .timer_io_pin_oe(timer_io_pin_oe), .dead_time_enable_o(dead_time_enable_o));

/* dv/tscdt_top_test.sv */
// Self-checking bench for the timer start and dead-time block.
// Assumes the pin model beside the block and an APB slave with wait states.
module tscdt_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pin_i;
    logic [2:0]  pin_o;
    logic [2:0]  pin_oe;
    logic [2:0]  ext_lvl;
    logic        dt_en;
    logic [7:0]  dt_val;
    logic [31:0] rd;
    logic        er;
    int          error_cnt;
    int          cmp_count;
    tscdt_top i_tscdt_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_io_pin_i(pin_i),
        .timer_io_pin_o(pin_o), .timer_io_pin_oe(pin_oe),
        .dead_time_enable_o(dt_en), .dead_time_value_o(dt_val));
    tscdt_pins_model i_tscdt_pins_model (
        .pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk(32'(n < 50), 32'h1, "pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h0);
        chk(rd, e, s);
    endtask
    task automatic wpin(input logic v);
        int n;
        n = 0;
        while (pin_o[0] !== v && n < 200)
        begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_reset();
        chk(32'(pin_o), 32'h0, "pin");
        chk(32'(pin_oe), 32'h7, "oe");
        chk(32'(dt_en), 32'h1, "dt out");
        rdc(12'h000, 32'h0, "start");
        rdc(12'h004, 32'h0, "ch5");
        rdc(12'h008, 32'h1, "dt");
        wr(12'h004, 32'h0);
        rdc(12'h004, 32'h0, "ch5 rsvd");
        apb(1'b0, 12'h01c, 32'h0);
        chk(32'(er), 32'h1, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_count();
        logic [11:0] ca [6] = '{12'h030, 12'h034, 12'h038, 12'h040, 12'h044, 12'h048};
        logic [31:0] v;
        logic [11:0] sa;
        for (int k = 0; k < 6; k++)
        begin
            sa = (k < 3) ? 12'h000 : 12'h004;
            wr(sa, 32'h1 << ((k < 3) ? k : 5 - k));
            wr(sa, 32'h0);
            apb(1'b0, ca[k], 32'h0);
            v = rd;
            chk(32'(v != 0), 32'h1, "ran");
            if (k < 5)
                rdc(ca[k + 1], 32'h0, "idle");
            tick(10);
            rdc(ca[k], v, "held");
        end
        $display("test count done");
    endtask
    task automatic t_out();
        logic e;
        for (int c = 0; c < 8; c++)
        begin
            e = (c[1:0] == 2'b00) ? pin_o[0] : c[2];
            wr(12'h010, 32'(c));
            tick(1);
            chk(32'(pin_o[0]), 32'(e), "init");
        end
        wr(12'h020, 32'd20);
        wr(12'h030, 32'h0);
        wr(12'h000, 32'h1);
        wpin(1'b0);
        chk(32'(pin_o[0]), 32'h0, "toggle");
        wr(12'h030, 32'h0);
        wpin(1'b1);
        chk(32'(pin_o[0]), 32'h1, "toggle2");
        wr(12'h000, 32'h0);
        tick(30);
        chk(32'(pin_o[0]), 32'h1, "kept");
        $display("test out done");
    endtask
    task automatic t_cap();
        logic [3:0] code [3] = '{4'h8, 4'h9, 4'ha};
        for (int k = 0; k < 3; k++)
        begin
            wr(12'h010, 32'(code[k]));
            tick(1);
            chk(32'(pin_oe[0]), 32'h0, "oe cap");
            wr(12'h020, 32'h0);
            wr(12'h000, 32'h1);
            ext_lvl <= 3'h1;
            tick(8);
            apb(1'b0, 12'h020, 32'h0);
            chk(32'(rd != 0), 32'(code[k] != 4'h9), "rise");
            wr(12'h020, 32'h0);
            ext_lvl <= 3'h0;
            tick(8);
            apb(1'b0, 12'h020, 32'h0);
            chk(32'(rd != 0), 32'(code[k] != 4'h8), "fall");
            wr(12'h000, 32'h0);
        end
        $display("test capture done");
    endtask
    task automatic t_dt();
        // All counters stopped before touching dead time
        // No synchronous clearing is ever issued
        wr(12'h00c, 32'h1);
        wr(12'h008, 32'h1);
        wr(12'h008, 32'h0);
        rdc(12'h008, 32'h1, "no read");
        wr(12'h008, 32'h0);
        rdc(12'h008, 32'h0, "cleared");
        wr(12'h008, 32'h1);
        rdc(12'h008, 32'h0, "no set");
        tick(2);
        chk(32'(dt_en), 32'h0, "dt out");
        chk(32'(dt_val), 32'h1, "dt val");
        $display("test dead time done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        $display("mismatch at %0t: watchdog", $time);
        end_sim();
    end
    initial
    begin
        error_cnt = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        ext_lvl = 3'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        tick(0);
        t_reset();
        t_count();
        t_out();
        t_cap();
        t_dt();
        end_sim();
    end
endmodule
